// *** hw/csg_defines.svh ***
/*
  constants for the calibration status group: register selectors, bit positions, masks,
  reset values.
  assumes it is included by bare name from the package and design files.
*/
`ifndef CSG_DEFINES_SVH
`define CSG_DEFINES_SVH
// How it works
// - event register clears on read or clear-status
// - enable mask cleared by writing zero
// - summary goes to status byte bit three
// - reported only when questionable mask enables it
// - bit 15 always reads zero
// - live condition bits zero to three
// - power auto-zero failure is event bit four
// - average-power zeroing failure is event bit five
// - channel power calibration failure is event bit six
// - baseband channel calibration error is event bit eight
// - rise and fall filters are read-write
`define CSG_SEL_COND      3'h0
`define CSG_SEL_RISE      3'h1
`define CSG_SEL_FALL      3'h2
`define CSG_SEL_EVENT     3'h3
`define CSG_SEL_MASK      3'h4
`define CSG_COND_MASK     16'h000F
`define CSG_EVONLY_MASK   16'h0170
`define CSG_USED_MASK     16'h017F
`define CSG_ZERO16        16'h0000
`define CSG_BIT_TXZERO    4
`define CSG_BIT_AVGZERO   5
`define CSG_BIT_CHPWR     6
`define CSG_BIT_BBCAL     8
`define CSG_STB_BIT       3
`define CSG_STB_RESET     8'h00
`endif

// *** hw/csg_pkg.sv ***
/*
  types for the calibration status group.
  assumes csg_defines.svh is on the include path.
*/
`include "csg_defines.svh"
package csg_pkg;
  typedef logic [15:0] csg_word_t;
  typedef logic [2:0]  csg_sel_t;
endpackage

// *** hw/csg_sync.sv ***
/*
  three-flop synchroniser for the eight asynchronous failure inputs; reports
  the agreed level and one-cycle edges.
  assumes inputs come from outside the CLK_SYS domain.
*/
`timescale 1ns/10ps
`default_nettype none
module csg_sync (
  input  wire logic CLK_SYS,
  input  wire logic RESET,
  csg_sync_if.sync  sif
);
  import csg_pkg::*;
  typedef struct packed
  {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
  } csg_sync_st_t;
  csg_sync_st_t st_reg;
  csg_sync_st_t st_next;

  // a change counts once second and third stage agree
  always_comb
  begin
    st_next     = st_reg;
    st_next.s1  = sif.raw;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.lvl = (st_reg.s2 & st_reg.s3) | (st_reg.lvl & (st_reg.s2 | st_reg.s3));
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // edges from the filtered level only, never from the first stage
  assign sif.level = st_reg.lvl;
  assign sif.rise  = st_next.lvl & ~st_reg.lvl;
  assign sif.fall  = ~st_next.lvl & st_reg.lvl;
endmodule
`default_nettype wire

// *** hw/csg_sync_if.sv ***
/*
  interface carrying raw and synchronised failure inputs between the top and the
  synchroniser.
  assumes one clock domain, CLK_SYS.
*/
`timescale 1ns/10ps
`default_nettype none
interface csg_sync_if;
  logic [7:0] raw;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] level;
  modport top (output raw, input rise, input fall, input level);
  modport sync (input raw, output rise, output fall, output level);
endinterface
`default_nettype wire

// *** hw/csg_top.sv ***
/*
  calibration status group: condition, rise/fall filters, latched events, enable mask
  and the summary that reaches status byte bit three through the questionable group.
  assumes the command parser issues one-cycle read and write strobes with a selector,
  and a one-cycle clear-status pulse; failure inputs are asynchronous levels.
*/
`timescale 1ns/10ps
`default_nettype none
`include "csg_defines.svh"
module csg_top (
  input  wire logic              CLK_SYS,
  input  wire logic              RESET,
  input  wire logic              SELFCAL_VM_FAIL,
  input  wire logic              SELFCAL_CNT_FAIL,
  input  wire logic              SELFCAL_SMP_FAIL,
  input  wire logic              SELFCAL_SA_FAIL,
  input  wire logic              TXZERO_FAIL,
  input  wire logic              AVGZERO_FAIL,
  input  wire logic              CHPWR_FAIL,
  input  wire logic              BBCAL_FAIL,
  input  wire logic              REG_RD,
  input  wire logic              REG_WR,
  input  wire csg_pkg::csg_sel_t REG_SEL,
  input  wire csg_pkg::csg_word_t REG_WDATA,
  input  wire logic              CLEAR_STATUS,
  input  wire logic              QUES_ENABLE_BIT,
  output logic                   REG_RVALID,
  output csg_pkg::csg_word_t     REG_RDATA,
  output logic                   GROUP_SUMMARY_BIT,
  output logic [7:0]             STATUS_BYTE
);
  import csg_pkg::*;

  typedef struct packed
  {
    csg_word_t cond;
    csg_word_t rise;
    csg_word_t fall;
    csg_word_t event_l;
    csg_word_t mask;
    csg_word_t rdata;
    logic      rvalid;
    logic      summ;
  } csg_state_t;

  csg_state_t st_reg;
  csg_state_t st_next;
  csg_word_t  cond_rise;
  csg_word_t  cond_fall;
  csg_word_t  direct_ev;
  csg_word_t  ev_set;
  csg_word_t  ev_now;
  logic       ev_clr;

  csg_sync_if sif ();

  // pack the failure pins; order sets the bit they report on
  assign sif.raw = {BBCAL_FAIL, CHPWR_FAIL, AVGZERO_FAIL, TXZERO_FAIL,
                    SELFCAL_VM_FAIL, SELFCAL_CNT_FAIL, SELFCAL_SMP_FAIL, SELFCAL_SA_FAIL};

  csg_sync u_sync (
    .CLK_SYS (CLK_SYS),
    .RESET   (RESET),
    .sif     (sif)
  );

  // keep only the implemented bits of a written word
  function automatic csg_word_t legal(input csg_word_t w);
    legal = w & `CSG_USED_MASK;
  endfunction

  // map the eight synced lanes onto register bit positions
  function automatic csg_word_t spread(input logic [7:0] v);
    csg_word_t w;
    w = `CSG_ZERO16;
    w[3:0] = v[3:0];
    w[`CSG_BIT_TXZERO]  = v[4];
    w[`CSG_BIT_AVGZERO] = v[5];
    w[`CSG_BIT_CHPWR]   = v[6];
    w[`CSG_BIT_BBCAL]   = v[7];
    spread = w;
  endfunction

  // edge and event sources
  always_comb
  begin
    cond_rise = spread(sif.rise) & `CSG_COND_MASK;
    cond_fall = spread(sif.fall) & `CSG_COND_MASK;
    direct_ev = spread(sif.rise) & `CSG_EVONLY_MASK;
    ev_set = (cond_rise & st_reg.rise) | (cond_fall & st_reg.fall) | direct_ev;
    ev_clr = CLEAR_STATUS | (REG_RD && REG_SEL == `CSG_SEL_EVENT);
  end

  // next state: new events win over a clear in the same cycle
  always_comb
  begin
    st_next        = st_reg;
    st_next.rvalid = REG_RD;
    st_next.cond   = spread(sif.level) & `CSG_COND_MASK;
    ev_now         = ev_clr ? `CSG_ZERO16 : st_reg.event_l;
    // bit 15 and unused bits never set
    st_next.event_l = legal(ev_now | ev_set);
    if (REG_WR)
    begin
      case (REG_SEL)
        `CSG_SEL_RISE: st_next.rise = legal(REG_WDATA);
        `CSG_SEL_FALL: st_next.fall = legal(REG_WDATA);
        `CSG_SEL_MASK: st_next.mask = legal(REG_WDATA);
        default: ;
      endcase
    end
    if (REG_RD)
    begin
      case (REG_SEL)
        `CSG_SEL_COND:  st_next.rdata = st_reg.cond;
        `CSG_SEL_RISE:  st_next.rdata = st_reg.rise;
        `CSG_SEL_FALL:  st_next.rdata = st_reg.fall;
        `CSG_SEL_EVENT: st_next.rdata = st_reg.event_l;
        `CSG_SEL_MASK:  st_next.rdata = st_reg.mask;
        default:        st_next.rdata = `CSG_ZERO16;
      endcase
    end
    st_next.summ = |(st_next.event_l & st_next.mask);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign REG_RVALID        = st_reg.rvalid;
  assign REG_RDATA         = st_reg.rdata;
  assign GROUP_SUMMARY_BIT = st_reg.summ;

  // status byte: only bit three belongs to this path
  always_comb
  begin
    STATUS_BYTE = `CSG_STB_RESET;
    STATUS_BYTE[`CSG_STB_BIT] = st_reg.summ & QUES_ENABLE_BIT;
  end

  AST_BIT15_ZERO: assert property (@(posedge CLK_SYS) disable iff (RESET)
    REG_RVALID |-> !REG_RDATA[15]) else $error("bit 15 read as one");

  AST_EVENT_READ_CLEARS: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REG_RD && REG_SEL == `CSG_SEL_EVENT && sif.rise == 8'h00 && sif.fall == 8'h00)
    |=> st_reg.event_l == `CSG_ZERO16) else $error("event not cleared by read");

  AST_CLS_CLEARS: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (CLEAR_STATUS && sif.rise == 8'h00 && sif.fall == 8'h00)
    |=> st_reg.event_l == `CSG_ZERO16) else $error("event not cleared by clear status");

  AST_MASK_ZERO: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REG_WR && REG_SEL == `CSG_SEL_MASK && REG_WDATA == `CSG_ZERO16)
    |=> st_reg.mask == `CSG_ZERO16) else $error("mask not cleared");

  AST_STB_GATE: assert property (@(posedge CLK_SYS) disable iff (RESET)
    STATUS_BYTE[`CSG_STB_BIT] == (GROUP_SUMMARY_BIT && QUES_ENABLE_BIT))
    else $error("status byte wrong");

  AST_STB_OTHERS: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (STATUS_BYTE & ~(8'h01 << `CSG_STB_BIT)) == `CSG_STB_RESET)
    else $error("status byte bit outside this path set");

  AST_AVGZERO_EVENT: assert property (@(posedge CLK_SYS) disable iff (RESET)
    sif.rise[5] |=> st_reg.event_l[`CSG_BIT_AVGZERO]) else $error("avg zero event lost");

  AST_BBCAL_EVENT: assert property (@(posedge CLK_SYS) disable iff (RESET)
    sif.rise[7] |=> st_reg.event_l[`CSG_BIT_BBCAL]) else $error("baseband event lost");

  AST_RISE_LATCH: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (sif.rise[3] && st_reg.rise[3]) |=> st_reg.event_l[3]) else $error("rise not latched");

  AST_FALL_LATCH: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (sif.fall[0] && st_reg.fall[0]) |=> st_reg.event_l[0]) else $error("fall not latched");

  AST_RISE_WRITE: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REG_WR && REG_SEL == `CSG_SEL_RISE)
    |=> st_reg.rise == ($past(REG_WDATA) & `CSG_USED_MASK))
    else $error("rise filter write lost");

  AST_SUMMARY: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ##1 GROUP_SUMMARY_BIT == |(st_reg.event_l & st_reg.mask)) else $error("summary wrong");

  AST_UNUSED_ZERO: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (st_reg.event_l & ~`CSG_USED_MASK) == `CSG_ZERO16) else $error("unused event bit set");

  AST_COND_LEVEL: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_reg.cond[15:4] == 12'h000) else $error("condition upper bits set");

  AST_COND_FOLLOWS: assert property (@(posedge CLK_SYS) disable iff (RESET)
    1'b1 |=> st_reg.cond[3:0] == $past(sif.level[3:0]))
    else $error("condition does not follow level");

  // main scenarios reached
  COV_EVENT_READ: cover property (@(posedge CLK_SYS)
    REG_RD && REG_SEL == `CSG_SEL_EVENT && st_reg.event_l != `CSG_ZERO16);
  COV_SUMMARY: cover property (@(posedge CLK_SYS) STATUS_BYTE[`CSG_STB_BIT]);
  COV_FALL: cover property (@(posedge CLK_SYS) sif.fall[0] && st_reg.fall[0]);
  COV_CLEAR_STATUS: cover property (@(posedge CLK_SYS)
    CLEAR_STATUS && st_reg.event_l != `CSG_ZERO16);
endmodule
`default_nettype wire

// *** tb/csg_ctrl_model.sv ***
/*
  remote controller model: issues one-cycle read, write and clear-status strobes.
  assumes tasks are entered just after a falling edge of clk.
*/
`timescale 1ns/10ps
`default_nettype none
module csg_ctrl_model
  import csg_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rvalid,
  input  wire csg_pkg::csg_word_t rdata,
  output var  logic          rd,
  output var  logic          wr,
  output var  logic          cls,
  output var  csg_pkg::csg_sel_t  sel,
  output var  csg_pkg::csg_word_t wdata
);
  import csg_pkg::*;
  // idle strobes low from time zero
  initial
  begin
    rd = 1'b0;
    wr = 1'b0;
    cls = 1'b0;
    sel = 3'h0;
    wdata = 16'h0000;
  end
  task automatic write(input csg_sel_t s, input csg_word_t d);
    sel = s;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~d;  // stale data never looks valid
    @(negedge clk);
  endtask
  // missing valid pulse turns the answer unknown
  task automatic read(input csg_sel_t s, output csg_word_t d);
    sel = s;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = (rvalid === 1'b1) ? rdata : 16'hxxxx;
    @(negedge clk);
  endtask
  task automatic clear();
    cls = 1'b1;
    @(negedge clk);
    cls = 1'b0;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
  self-checking bench for csg_top.
  assumes csg_pkg and the design are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "csg_defines.svh"
module tb_top;
  import csg_pkg::*;
  logic       clk, rst, ques, rd, wr, cls, rvalid, summary;
  logic [7:0] fail, stb;
  csg_sel_t   sel;
  csg_word_t  wdata, rdata, v;
  int         errors, cmp_count, cycles;
  csg_top i_csg_top (.CLK_SYS(clk), .RESET(rst), .SELFCAL_VM_FAIL(fail[3]),
    .SELFCAL_CNT_FAIL(fail[2]), .SELFCAL_SMP_FAIL(fail[1]), .SELFCAL_SA_FAIL(fail[0]),
    .TXZERO_FAIL(fail[4]), .AVGZERO_FAIL(fail[5]), .CHPWR_FAIL(fail[6]),
    .BBCAL_FAIL(fail[7]), .REG_RD(rd), .REG_WR(wr), .REG_SEL(sel), .REG_WDATA(wdata),
    .CLEAR_STATUS(cls), .QUES_ENABLE_BIT(ques), .REG_RVALID(rvalid), .REG_RDATA(rdata),
    .GROUP_SUMMARY_BIT(summary), .STATUS_BYTE(stb));
  csg_ctrl_model i_csg_ctrl_model (.clk(clk), .rvalid(rvalid), .rdata(rdata), .rd(rd),
    .wr(wr), .cls(cls), .sel(sel), .wdata(wdata));
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input csg_word_t seen, input csg_word_t exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input csg_sel_t s, input csg_word_t exp);
    i_csg_ctrl_model.read(s, v);
    check(v, exp);
  endtask
  // pin change needs five cycles to reach the condition
  task automatic pin(input int b, input logic lv);
    fail[b] = lv;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_reset();
    for (int s = 0; s < 6; s++)
      rdchk(csg_sel_t'(s), 16'h0000);
  endtask
  task automatic t_filters();
    i_csg_ctrl_model.write(`CSG_SEL_RISE, 16'hFFFF);
    rdchk(`CSG_SEL_RISE, 16'h017F);
    i_csg_ctrl_model.write(`CSG_SEL_FALL, 16'h8005);
    rdchk(`CSG_SEL_FALL, 16'h0005);
    // condition is live only; a write must not land
    i_csg_ctrl_model.write(`CSG_SEL_COND, 16'hFFFF);
    rdchk(`CSG_SEL_COND, 16'h0000);
  endtask
  // mid-run reset wipes the filters
  task automatic t_midreset();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rdchk(`CSG_SEL_RISE, 16'h0000);
    rdchk(`CSG_SEL_FALL, 16'h0000);
  endtask
  task automatic t_cond();
    i_csg_ctrl_model.write(`CSG_SEL_RISE, 16'h000F);
    i_csg_ctrl_model.write(`CSG_SEL_FALL, 16'h0004);
    pin(3, 1'b1);
    pin(0, 1'b1);
    rdchk(`CSG_SEL_COND, 16'h0009);
    rdchk(`CSG_SEL_EVENT, 16'h0009);
    rdchk(`CSG_SEL_EVENT, 16'h0000);
    pin(2, 1'b1);
    rdchk(`CSG_SEL_EVENT, 16'h0004);
    pin(3, 1'b0);
    pin(0, 1'b0);
    pin(2, 1'b0);
    rdchk(`CSG_SEL_EVENT, 16'h0004);
  endtask
  task automatic t_evonly();
    for (int b = 4; b < 8; b++)
    begin
      pin(b, 1'b1);
      pin(b, 1'b0);
    end
    rdchk(`CSG_SEL_EVENT, 16'h0170);
    pin(4, 1'b1);
    i_csg_ctrl_model.clear();
    rdchk(`CSG_SEL_EVENT, 16'h0000);
    pin(4, 1'b0);
  endtask
  task automatic t_summary();
    i_csg_ctrl_model.write(`CSG_SEL_MASK, 16'hFFFF);
    rdchk(`CSG_SEL_MASK, 16'h017F);
    pin(5, 1'b1);
    check({15'h0000, summary}, 16'h0001);
    ques = 1'b1;
    @(negedge clk);
    check({8'h00, stb}, 16'h0008);
    ques = 1'b0;
    @(negedge clk);
    check({8'h00, stb}, 16'h0000);
    i_csg_ctrl_model.write(`CSG_SEL_MASK, 16'h0000);
    check({15'h0000, summary}, 16'h0000);
    rdchk(`CSG_SEL_MASK, 16'h0000);
    rdchk(`CSG_SEL_EVENT, 16'h0020);
  endtask
  // free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well above the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'b1;
    fail = 8'h00;
    ques = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_filters();
    t_midreset();
    t_cond();
    t_evonly();
    t_summary();
    wrap_up();
  end
endmodule
`default_nettype wire
